// ==== imbs_bank.sv ====
// Input monitor configuration registers and leaky-bucket set selection
//
// Function
// - Eight-bit read/write second input config register at 0x21, reset to zero.
// - Bits 5:4 of it choose bucket configuration 0 to 3 for second input.
// - Each input has own monitor; two-bit selector picks among sets at 0x50-0x5F.
// - First input selector value 11 makes its monitor use configuration 3.
`timescale 1ns/1ns
`include "imbs_defs.svh"
module imbs_bank (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Processor register port
  input wire imbs_pkg::imbs_byte_type reg_addr,
  input wire imbs_pkg::imbs_byte_type reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output imbs_pkg::imbs_byte_type reg_rdata,
  output logic reg_rvalid,
  // Selectors seen by the activity monitors
  output imbs_pkg::imbs_sel_type first_input_bucket_select,
  output imbs_pkg::imbs_sel_type second_input_bucket_select,
  // Chosen leaky-bucket parameters per input
  output imbs_pkg::imbs_set_type first_bucket_params,
  output imbs_pkg::imbs_set_type second_bucket_params
);
  import imbs_pkg::*;

  localparam int SET_BYTES = `IMBS_SET_COUNT * `IMBS_BYTES_PER_SET;

  // Register storage; sixteen bucket bytes are cheap enough as flops
  // and keep every set readable in the same cycle
  imbs_byte_type first_input_config;
  imbs_byte_type second_input_monitor_config;
  imbs_byte_type bucket_mem [0:SET_BYTES-1];
  imbs_set_type bucket_set [0:`IMBS_SET_COUNT-1];

  // Address decode
  logic hit_first_cfg;
  logic hit_second_cfg;
  logic in_bucket_range;
  logic [`IMBS_BUCKET_INDEX_MSB:0] bucket_index;

  // Write enables
  logic first_cfg_wr;
  logic second_cfg_wr;
  logic [SET_BYTES-1:0] bucket_byte_wr;

  // Stored selector fields
  imbs_sel_type first_field;
  imbs_sel_type second_field;

  // Read data for the current strobe
  imbs_byte_type bucket_rd_byte;
  imbs_byte_type next_reg_rdata;

  // Windows do not overlap, so the chain order carries no priority;
  // an unmapped address leaves every hit low and is ignored on write
  always_comb begin
    hit_first_cfg = 1'b0;
    hit_second_cfg = 1'b0;
    in_bucket_range = 1'b0;
    if (reg_addr == `IMBS_FIRST_CFG_ADDR) begin
      hit_first_cfg = 1'b1;
    end else if (reg_addr == `IMBS_SECOND_CFG_ADDR) begin
      hit_second_cfg = 1'b1;
    end else if ((reg_addr >= `IMBS_BUCKET_BASE_ADDR) &&
                 (reg_addr <= `IMBS_BUCKET_LAST_ADDR)) begin
      in_bucket_range = 1'b1;
    end
  end

  // Low address bits pick the byte inside the bucket window
  assign bucket_index = reg_addr[`IMBS_BUCKET_INDEX_MSB:0];
  assign bucket_rd_byte = bucket_mem[bucket_index];

  // A read and a write in one cycle return the old value, since reads use the flops
  assign first_cfg_wr = reg_wr && hit_first_cfg;
  assign second_cfg_wr = reg_wr && hit_second_cfg;

  // One write enable per bucket byte; at most one is high in any cycle
  // because the index comes from a single address
  generate
    for (genvar b = 0; b < SET_BYTES; b++) begin : g_byte_wr
      assign bucket_byte_wr[b] = reg_wr && in_bucket_range &&
                                 (int'(bucket_index) == b);
    end
  endgenerate

  // First input configuration, full byte kept; only its selector
  // field is decoded here
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      first_input_config <= `IMBS_CFG_RESET;
    end else if (first_cfg_wr) begin
      first_input_config <= reg_wdata;
    end
  end

  // Reserved bits are stored as written; software is expected to keep them zero.
  // Forcing them low would hide a software fault that then reads back clean
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      second_input_monitor_config <= `IMBS_CFG_RESET;
    end else if (second_cfg_wr) begin
      second_input_monitor_config <= reg_wdata;
    end
  end

  // Shared leaky-bucket parameter storage; a byte write reaches the
  // parameters of every input on that set one edge later
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < SET_BYTES; i++) begin
      if (sys_rst) begin
        bucket_mem[i] <= `IMBS_BUCKET_RESET;
      end else if (bucket_byte_wr[i]) begin
        bucket_mem[i] <= reg_wdata;
      end
    end
  end

  // Sets are little-endian groups of four bytes, lowest address in bits 7:0
  generate
    for (genvar k = 0; k < `IMBS_SET_COUNT; k++) begin : g_set
      localparam int BASE = k * `IMBS_BYTES_PER_SET;
      assign bucket_set[k] = {bucket_mem[BASE+3], bucket_mem[BASE+2],
                              bucket_mem[BASE+1], bucket_mem[BASE]};
    end
  endgenerate

  // Unmapped addresses read as zero so software never sees stale data;
  // the bucket bytes read back exactly as written
  always_comb begin
    if (hit_first_cfg) begin
      next_reg_rdata = first_input_config;
    end else if (hit_second_cfg) begin
      next_reg_rdata = second_input_monitor_config;
    end else if (in_bucket_range) begin
      next_reg_rdata = bucket_rd_byte;
    end else begin
      next_reg_rdata = `IMBS_UNMAPPED_READ;
    end
  end

  // Read data stands until the next read, so software may fetch it late
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= `IMBS_UNMAPPED_READ;
    end else if (reg_rd) begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // Answer strobe, one cycle per read strobe; back-to-back reads give
  // back-to-back answers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end

  // Only bits 5:4 steer logic; the rest of each byte is plain storage
  // and has no effect on the monitors
  assign first_field = first_input_config[`IMBS_SEL_MSB:`IMBS_SEL_LSB];
  assign second_field = second_input_monitor_config[`IMBS_SEL_MSB:`IMBS_SEL_LSB];

  // Selector outputs follow the registers one cycle later, on the same
  // edge as the chosen parameters, so a monitor never sees them disagree
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      first_input_bucket_select <= `IMBS_SEL_RESET;
    end else begin
      first_input_bucket_select <= first_field;
    end
  end

  // Second input selector
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      second_input_bucket_select <= `IMBS_SEL_RESET;
    end else begin
      second_input_bucket_select <= second_field;
    end
  end

  // One picker per input monitor, all sharing the same four sets;
  // each takes the stored field so its output lines up with the selector
  imbs_bucket_pick u_first_pick (
    // Clock and reset
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    // Selector from the first input's register
    .bucket_select(first_field),
    // Shared sets
    .set0(bucket_set[0]),
    .set1(bucket_set[1]),
    .set2(bucket_set[2]),
    .set3(bucket_set[3]),
    // Chosen set
    .bucket_params(first_bucket_params)
  );

  imbs_bucket_pick u_second_pick (
    // Clock and reset
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    // Selector from the second input's register
    .bucket_select(second_field),
    // Shared sets
    .set0(bucket_set[0]),
    .set1(bucket_set[1]),
    .set2(bucket_set[2]),
    .set3(bucket_set[3]),
    // Chosen set
    .bucket_params(second_bucket_params)
  );
endmodule // imbs_bank

// ==== imbs_defs.svh ====
// Address map, field positions and reset values of the input monitor bucket select bank
`ifndef IMBS_DEFS_SVH
`define IMBS_DEFS_SVH

`define IMBS_FIRST_CFG_ADDR 8'h20
`define IMBS_SECOND_CFG_ADDR 8'h21
`define IMBS_BUCKET_BASE_ADDR 8'h50
`define IMBS_BUCKET_LAST_ADDR 8'h5F
`define IMBS_BUCKET_INDEX_MSB 3
`define IMBS_CFG_RESET 8'h00
`define IMBS_BUCKET_RESET 8'h00
`define IMBS_UNMAPPED_READ 8'h00
`define IMBS_SEL_MSB 5
`define IMBS_SEL_LSB 4
`define IMBS_SET_COUNT 4
`define IMBS_BYTES_PER_SET 4
`define IMBS_PARAMS_RESET 32'h0000_0000
`define IMBS_SEL_RESET 2'h0

`endif

// ==== imbs_pkg.sv ====
// Types shared by the input monitor bucket select bank
package imbs_pkg;
  typedef logic [7:0] imbs_byte_type;
  typedef logic [1:0] imbs_sel_type;
  typedef logic [31:0] imbs_set_type;
endpackage

// ==== imbs_bucket_pick.sv ====
// Picks one of four shared leaky-bucket parameter sets for one input monitor
`timescale 1ns/1ns
`include "imbs_defs.svh"
module imbs_bucket_pick (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Selector and shared sets
  input wire imbs_pkg::imbs_sel_type bucket_select,
  input wire imbs_pkg::imbs_set_type set0,
  input wire imbs_pkg::imbs_set_type set1,
  input wire imbs_pkg::imbs_set_type set2,
  input wire imbs_pkg::imbs_set_type set3,
  // Chosen set, registered
  output imbs_pkg::imbs_set_type bucket_params
);
  import imbs_pkg::*;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bucket_params <= `IMBS_PARAMS_RESET;
    end else begin
      case (bucket_select)
        2'h0: bucket_params <= set0;
        2'h1: bucket_params <= set1;
        2'h2: bucket_params <= set2;
        default: bucket_params <= set3;
      endcase
    end
  end
endmodule // imbs_bucket_pick

// ==== imbs_bank_asserts.sv ====
// Port assertions for the bucket select bank
`timescale 1ns/1ns
module imbs_bank_chk (
  // Clock, reset and port
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire imbs_pkg::imbs_byte_type reg_addr,
  input wire imbs_pkg::imbs_byte_type reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_rvalid,
  input wire imbs_pkg::imbs_sel_type first_input_bucket_select,
  input wire imbs_pkg::imbs_sel_type second_input_bucket_select
);
  import imbs_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  a_rvalid_pulse: assert property (!reg_rd |=> !reg_rvalid)
    else $error("stray read answer");
  a_second_sel: assert property (reg_wr && reg_addr == 8'h21 ##1 !reg_wr |=>
    second_input_bucket_select == $past(reg_wdata[5:4], 2)) else $error("second select wrong");
  a_first_sel: assert property (reg_wr && reg_addr == 8'h20 ##1 !reg_wr |=>
    first_input_bucket_select == $past(reg_wdata[5:4], 2)) else $error("first select wrong");
  cover property (reg_rvalid);
  cover property (second_input_bucket_select == 2'h3);
  cover property (first_input_bucket_select == 2'h3);
endmodule // imbs_bank_chk
bind imbs_bank imbs_bank_chk u_chk (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rvalid, .first_input_bucket_select, .second_input_bucket_select);

// ==== tb_top.sv ====
// Self-checking bench for the bucket select bank
`timescale 1ns/1ns
module tb_top;
  import imbs_pkg::*;
  logic core_clk = 0;
  logic sys_rst = 1;
  imbs_byte_type reg_addr = 8'h00;
  imbs_byte_type reg_wdata = 8'h00;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic reg_rvalid;
  imbs_byte_type reg_rdata, got;
  imbs_byte_type bkt [16];
  imbs_sel_type sel1, sel2;
  imbs_set_type par1, par2;
  int num_errors = 0;
  int check_count = 0;
  always #5 core_clk = ~core_clk;
  imbs_bank u_dut (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .reg_rvalid, .first_input_bucket_select(sel1),
    .second_input_bucket_select(sel2), .first_bucket_params(par1),
    .second_bucket_params(par2));
  function automatic imbs_set_type exp_set(int k);
    return {bkt[4*k+3], bkt[4*k+2], bkt[4*k+1], bkt[4*k]};
  endfunction
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(imbs_byte_type a, imbs_byte_type d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge core_clk);
    reg_wr <= 0;
  endtask
  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic rd(imbs_byte_type a);
    int i;
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge core_clk);
    reg_rd <= 0;
    // Answer stands only in the cycle after the strobe edge
    for (i = 0; i < 4; i++) begin
      #1;
      if (reg_rvalid === 1'b1) break;
      @(posedge core_clk);
    end
    got = reg_rdata;
    if (i == 4) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  initial begin
    void'($urandom(32'h477e));
    repeat (16) @(posedge core_clk);
    sys_rst <= 0;
    rd(8'h21);
    check("cfg reset", got, 8'h00);
    rd(8'h10);
    check("unmapped", got, 8'h00);
    for (int a = 0; a < 16; a++) begin
      bkt[a] = 8'($urandom);
      wr(8'(8'h50 + a), bkt[a]);
    end
    for (int a = 0; a < 16; a += 5) begin
      rd(8'(8'h50 + a));
      check("bucket byte", got, bkt[a]);
    end
    // Descending so second input ends on set 0
    for (int k = 3; k >= 0; k--) begin
      wr(8'h21, {2'b00, k[1:0], 4'h0});
      settle();
      check("second sel", sel2, k);
      check("second params", par2, exp_set(k));
      rd(8'h21);
      check("second cfg", got, k << 4);
    end
    wr(8'h20, 8'h30);
    settle();
    check("first sel", sel1, 2'h3);
    check("first params", par1, exp_set(3));
    check("second kept", sel2, 2'h0);
    rd(8'h20);
    check("first cfg", got, 8'h30);
    bkt[0] = 8'($urandom);
    wr(8'h50, bkt[0]);
    settle();
    check("set0 update", par2, exp_set(0));
    report_and_stop();
  end
endmodule // tb_top
